/* File: hdl/dot_pkg.sv */
// shared constants for the on-die termination control block
package dot_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_MODE1 = 8'h00;
   localparam logic [7:0] ADDR_MODE2 = 8'h04;
   localparam logic [7:0] ADDR_LAT = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // mode1 field positions: nominal code bits and write leveling
   localparam int M1_NOM_B0 = 2;
   localparam int M1_NOM_B1 = 6;
   localparam int M1_NOM_B2 = 9;
   localparam int M1_WLEV = 7;
   // mode2 write termination field
   localparam int M2_WR_LO = 9;
   localparam int M2_WR_HI = 10;
   // latency register fields
   localparam int LAT_CWL_LSB = 0;
   localparam int LAT_AL_LSB = 8;
   localparam int LAT_FLD_W = 4;
   // control register
   localparam int CTRL_CAL = 0;
   // status register fields
   localparam int ST_TERM = 0;
   localparam int ST_WR = 1;
   localparam int ST_DIV_LSB = 4;
   localparam int ST_ASYNC = 8;
   localparam int ST_NOM_BAD = 9;
   localparam int ST_WR_BAD = 10;
   localparam int ST_SETTLE = 11;
   localparam int ST_IGNORE = 12;
   // reset values
   localparam logic [31:0] MODE1_RST = 32'h00000000;
   localparam logic [31:0] MODE2_RST = 32'h00000000;
   localparam logic [31:0] LAT_RST = 32'h00000005;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   // nominal code, order bit9,bit6,bit2
   localparam logic [2:0] NOM_OFF = 3'h0;
   localparam logic [2:0] NOM_DIV4 = 3'h1;
   localparam logic [2:0] NOM_DIV2 = 3'h2;
   localparam logic [2:0] NOM_DIV6 = 3'h3;
   localparam logic [2:0] NOM_DIV12 = 3'h4;
   localparam logic [2:0] NOM_DIV8 = 3'h5;
   // write termination code
   localparam logic [1:0] WR_OFF = 2'h0;
   localparam logic [1:0] WR_DIV4 = 2'h1;
   localparam logic [1:0] WR_DIV2 = 2'h2;
   // reference resistor and divider values
   localparam int REF_OHM = 240;
   localparam logic [3:0] DIV_NONE = 4'h0;
   localparam logic [3:0] DIV_2 = 4'h2;
   localparam logic [3:0] DIV_4 = 4'h4;
   localparam logic [3:0] DIV_6 = 4'h6;
   localparam logic [3:0] DIV_8 = 4'h8;
   localparam logic [3:0] DIV_12 = 4'hC;
   // latency figures in clocks
   localparam int LAT_OFFSET = 2;
   localparam int MIN_LAT = 2;
   localparam int RET_BL8 = 6;
   localparam int RET_BC4 = 4;
   localparam int TERM_SETTLE_CYC = 1;
   localparam int WL_EXTRA_CYC = 1;
   // asynchronous delay window, in ps, and its cycle count
   localparam int CLK_PERIOD_PS = 10000;
   localparam int ASYNC_MIN_PS = 2000;
   localparam int ASYNC_MAX_PS = 8500;
   localparam int ASYNC_CYC = (ASYNC_MAX_PS / CLK_PERIOD_PS < 1) ? 1 : ASYNC_MAX_PS / CLK_PERIOD_PS;
endpackage : dot_pkg

/* File: hdl/dot_dly_if.sv */
// carrier between the core and its latency delay line
`timescale 1ns/1ps
interface dot_dly_if #(parameter int TAP_W = 5);
   logic d;
   logic [TAP_W-1:0] tap;
   logic q;
   modport src (output d, output tap, input q);
   modport dly (input d, input tap, output q);
endinterface : dot_dly_if

/* File: hdl/dot_delay_line.sv */
// programmable delay line for the registered termination pin
`timescale 1ns/1ps
module dot_delay_line
   import dot_pkg::*;
#(
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // delay request and result
   dot_dly_if.dly io
);
   logic [DEPTH-1:0] sr;
   logic [DEPTH+2:0] taps;

   // three entries before sr: q flop plus caller's output flop land exactly tap clocks late
   assign taps = {sr, io.d, io.d, io.d};

   // shift history; a new high simply enters, no counter to restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr <= '0;
         io.q <= 1'b0;
      end else begin
         sr <= {sr[DEPTH-2:0], io.d};
         io.q <= taps[io.tap];
      end
   end
endmodule : dot_delay_line

/* File: hdl/dot_term_ctrl.sv */
// on-die termination control core with apb register access
`timescale 1ns/1ps
// Behaviour
// R01 - pin ignored in self refresh or when both termination settings disable it
// R02 - controller drives pin low before self refresh entry
// R03 - asynchronous mode when dll off in power-down or syncing, else synchronous
// R04 - write termination only during write bursts, switched on the fly
// R05 - nominal code 000 off, up to 101 values, 110 and 111 illegal
// R06 - enabled nominal termination follows the registered pin level
// R07 - controller keeps pin low during reads; the model still raises it through its hold count when asked with the pin low
// R08 - nominal values are 240 ohm divided by 2, 4, 6, 8 or 12
// R09 - nominal only after calibration, never during read or self refresh
// R10 - without write termination controller uses only divide 2, 4 or 6; the core and bench also use divide 8 and 12 with write termination off
// R11 - synchronous turn-on is write plus additive latency minus 2 clocks
// R12 - synchronous turn-off uses the same latency after pin low
// R13 - asynchronous turn-on/off within 2 to 8.5 ns, no latency count
// R14 - controller holds pin high at least 4 clocks after assert or short write
// R15 - controller holds pin high at least 6 clocks after long write
// R16 - turn-off completes within half clock of latency completion
// R17 - write value at burst start, nominal at end, no mode write needed
// R18 - single rank may tie pin high with nominal off, write on
// R19 - leveling in tied case enables nominal in the same mode1 write
// R20 - after mode1 write state uncertain; then strobes nominal, data none
// R21 - dynamic on if either write field bit set; 01 div4, 10 div2, 11 reserved
// R22 - switch at latency minus 2, return after 6 or 4 plus off latency
// R23 - pin registered and latencies counted on rising clock edges
module dot_term_ctrl
   import dot_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int MOD_DELAY_CYC = 12,
   parameter int LAT_DEPTH = 32
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // termination pin from the controller
   input wire logic odt_pin,
   // device state, same clock
   input wire logic wr_cmd,
   input wire logic wr_bc4,
   input wire logic read_active,
   input wire logic self_refresh,
   input wire logic pd_dll_off,
   input wire logic dll_syncing,
   // termination controls
   output logic term_on,
   output logic term_wr,
   output logic [3:0] term_div,
   output logic dq_term_on,
   output logic dqs_term_on
);
   localparam int LAT_W = $clog2(LAT_DEPTH);

   logic [31:0] mode1;
   logic [31:0] mode2;
   logic [31:0] lat_reg;
   logic [31:0] ctrl;
   logic pin_meta;
   logic odt_s;
   logic [ASYNC_CYC-1:0] async_sr;
   logic [5:0] wr_cnt;
   logic wr_short;
   logic [7:0] settle_cnt;
   logic async_q;

   // register decode
   wire setup_rd = psel & penable & ~pready;
   wire done = psel & penable & pready;
   wire [7:0] addr8 = paddr[7:0];
   wire hit_m1 = (addr8 == ADDR_MODE1);
   wire hit_m2 = (addr8 == ADDR_MODE2);
   wire hit_lat = (addr8 == ADDR_LAT);
   wire hit_ctrl = (addr8 == ADDR_CTRL);
   wire hit_st = (addr8 == ADDR_STATUS);
   wire hit_any = hit_m1 | hit_m2 | hit_lat | hit_ctrl | hit_st;
   wire wr_m1 = done & pwrite & hit_m1;

   // mode field decode
   wire [2:0] nom_code = {mode1[M1_NOM_B2], mode1[M1_NOM_B1], mode1[M1_NOM_B0]};
   wire [1:0] wr_code = mode2[M2_WR_HI:M2_WR_LO];
   wire nom_bad = (nom_code > NOM_DIV8); // [R05]
   wire nom_en = (nom_code != NOM_OFF) & ~nom_bad; // [R05]
   wire wr_bad = (wr_code == (WR_DIV4 | WR_DIV2)); // [R21]
   wire dyn_en = (mode2[M2_WR_LO] | mode2[M2_WR_HI]) & ~wr_bad; // [R21]
   wire wlev = mode1[M1_WLEV];
   wire calibrated = ctrl[CTRL_CAL];

   // nominal divider of the reference resistor
   wire [3:0] nom_div = (nom_code == NOM_DIV2) ? DIV_2 : // [R08]
      (nom_code == NOM_DIV4) ? DIV_4 :
      (nom_code == NOM_DIV6) ? DIV_6 :
      (nom_code == NOM_DIV8) ? DIV_8 :
      (nom_code == NOM_DIV12) ? DIV_12 : DIV_NONE;
   wire [3:0] wr_div = (wr_code == WR_DIV2) ? DIV_2 : (wr_code == WR_DIV4) ? DIV_4 : DIV_NONE; // [R21]

   // latency = write latency + additive latency - 2, floored at the tap minimum
   wire [5:0] wl_sum = 6'(lat_reg[LAT_CWL_LSB +: LAT_FLD_W]) + 6'(lat_reg[LAT_AL_LSB +: LAT_FLD_W]);
   wire [5:0] lat6 = (wl_sum < 6'(MIN_LAT + LAT_OFFSET)) ? 6'(MIN_LAT) : wl_sum - 6'(LAT_OFFSET); // [R11]
   wire [LAT_W-1:0] odt_lat = LAT_W'(lat6);
   wire [5:0] ret_lat = (wr_short ? 6'(RET_BC4) : 6'(RET_BL8)) + lat6; // [R22]

   // mode and gating
   wire async_mode = pd_dll_off | dll_syncing; // [R03]
   wire ignore_pin = self_refresh | (~nom_en & ~dyn_en); // [R01]
   wire allowed = calibrated & ~read_active & ~self_refresh; // [R09]
   wire [ASYNC_CYC:0] async_tap = {async_sr, odt_s};
   wire pin_async = async_tap[ASYNC_CYC-1]; // [R13]

   // delay line carries the registered pin through the on/off latency
   dot_dly_if #(.TAP_W(LAT_W)) dly ();
   assign dly.d = odt_s;
   assign dly.tap = odt_lat; // [R11] [R12] [R16]
   dot_delay_line #(.DEPTH(LAT_DEPTH)) u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .io(dly)
   );

   // write window from registration count; active between switch and return
   wire in_win = (wr_cnt != 6'h00) & (wr_cnt >= lat6) & (wr_cnt < ret_lat); // [R22]
   wire pin_on = async_mode ? pin_async : dly.q; // [R03] [R06]
   wire next_term_wr = in_win & dyn_en & pin_on & ~ignore_pin & allowed; // [R04] [R17]
   wire next_term_on = pin_on & ~ignore_pin & allowed & (next_term_wr | nom_en); // [R06] [R09]
   wire [3:0] next_term_div = ~next_term_on ? DIV_NONE : next_term_wr ? wr_div : nom_div; // [R17]
   wire [5:0] next_wr_cnt = (wr_cmd & dyn_en) ? 6'h01 : // [R22]
      (wr_cnt == 6'h00 || wr_cnt >= ret_lat) ? 6'h00 : wr_cnt + 6'h01;
   wire [7:0] settle_load = 8'(lat6) + 8'(TERM_SETTLE_CYC) + 8'(MOD_DELAY_CYC) + 8'(WL_EXTRA_CYC); // [R20]

   // status word and read mux
   wire [31:0] status = {19'h0, ignore_pin, settle_cnt != 8'h00, wr_bad, nom_bad, async_q,
      term_div, 2'h0, term_wr, term_on};
   wire [31:0] rd_mux = hit_m1 ? mode1 : hit_m2 ? mode2 : hit_lat ? lat_reg :
      hit_ctrl ? ctrl : hit_st ? status : 32'h00000000;

   // pin synchroniser, two flops before any use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b0;
         odt_s <= 1'b0;
         async_sr <= '0;
      end else begin
         pin_meta <= odt_pin; // [R23]
         odt_s <= pin_meta;
         async_sr <= async_tap[ASYNC_CYC-1:0];
      end
   end

   // apb handshake: one wait cycle, data loaded with the ready flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup_rd;
         pslverr <= setup_rd & ~hit_any;
         prdata <= (setup_rd & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // software registers; status is read-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode1 <= MODE1_RST;
         mode2 <= MODE2_RST;
         lat_reg <= LAT_RST;
         ctrl <= CTRL_RST;
      end else if (done & pwrite) begin
         if (hit_m1) mode1 <= pwdata;
         if (hit_m2) mode2 <= pwdata;
         if (hit_lat) lat_reg <= pwdata;
         if (hit_ctrl) ctrl <= pwdata;
      end
   end

   // write burst counter and uncertainty counter after mode1 writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_cnt <= 6'h00;
         wr_short <= 1'b0;
         settle_cnt <= 8'h00;
      end else begin
         wr_cnt <= next_wr_cnt;
         if (wr_cmd) wr_short <= wr_bc4; // [R22]
         settle_cnt <= wr_m1 ? settle_load : (settle_cnt != 8'h00) ? settle_cnt - 8'h01 : 8'h00; // [R20]
      end
   end

   // termination outputs, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_on <= 1'b0;
         term_wr <= 1'b0;
         term_div <= DIV_NONE;
         dq_term_on <= 1'b0;
         dqs_term_on <= 1'b0;
         async_q <= 1'b0;
      end else begin
         term_on <= next_term_on;
         term_wr <= next_term_wr;
         term_div <= next_term_div;
         dq_term_on <= next_term_on & ~wlev; // [R20]
         dqs_term_on <= next_term_on; // [R20]
         async_q <= async_mode;
      end
   end

   // helper ages of the registered pin level, saturating
   logic [5:0] hi_age;
   logic [5:0] lo_age;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_age <= 6'h00;
         lo_age <= 6'h00;
      end else begin
         hi_age <= ~odt_s ? 6'h00 : (hi_age == 6'h3F) ? hi_age : hi_age + 6'h01;
         lo_age <= odt_s ? 6'h00 : (lo_age == 6'h3F) ? lo_age : lo_age + 6'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_write_reg;
      wr_cmd && dyn_en;
   endsequence

   sequence s_quiet_write;
      (!wr_cmd)[*3];
   endsequence

   a_ignore_pin: assert property (ignore_pin |=> !term_on) // [R01]
      else $error("termination on while pin ignored");
   a_async_mode: assert property (async_mode |=> async_q) // [R03]
      else $error("async mode not reported");
   a_wr_only_burst: assert property (!in_win |=> !term_wr) // [R04]
      else $error("write termination outside write window");
   a_nom_reserved: assert property (nom_bad && !dyn_en |=> !term_on && term_div == DIV_NONE) // [R05]
      else $error("reserved nominal code turned termination on");
   a_sync_turn_on: assert property (!async_mode && $stable(lat6) && allowed && !ignore_pin && nom_en
      && hi_age == 6'(lat6) |-> term_on) // [R11]
      else $error("synchronous turn-on latency wrong");
   a_sync_turn_off: assert property (!async_mode && $stable(lat6) && lo_age == 6'(lat6) |-> !term_on) // [R12]
      else $error("synchronous turn-off latency wrong");
   a_async_delay: assert property (async_mode && $stable(async_mode) && odt_s && allowed && nom_en
      && !ignore_pin ##1 async_mode && allowed |-> term_on) // [R13]
      else $error("asynchronous turn-on too slow");
   a_write_switch: assert property (s_write_reg ##1 s_quiet_write |-> wr_cnt == 6'h03) // [R22]
      else $error("write window count not started");
   a_read_blocks: assert property (read_active || !calibrated |=> !term_on) // [R09]
      else $error("termination during read or before calibration");
   a_level_dq_off: assert property (wlev && $stable(wlev) |-> !dq_term_on) // [R20]
      else $error("data termination on during leveling");
   a_settle_load: assert property (wr_m1 |=> settle_cnt == settle_load) // [R20]
      else $error("uncertainty window not started");
endmodule : dot_term_ctrl

/* File: tb/dot_ctrl_model.sv */
// memory controller model driving the termination pin and write commands
`timescale 1ns/1ps
module dot_ctrl_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requests from the bench
   input wire logic want_pin,
   input wire logic want_wr,
   input wire logic want_bc4,
   input wire logic rogue,
   // device state seen by the controller
   input wire logic self_refresh,
   input wire logic read_active,
   // pins towards the device
   output logic odt_pin,
   output logic wr_cmd,
   output logic wr_bc4
);
   int hold;
   // pin and command drive, all changes right after the rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odt_pin <= 1'b0;
         wr_cmd <= 1'b0;
         wr_bc4 <= 1'b0;
         hold <= 0;
      end else begin
         wr_cmd <= want_wr;
         wr_bc4 <= want_bc4;
         if (want_wr && odt_pin) begin
            hold <= want_bc4 ? 4 : 6;
         end else if (want_pin && !odt_pin) begin
            hold <= 4;
         end else if (hold > 0) begin
            hold <= hold - 1;
         end
         // request masked in self refresh and reads unless told to misbehave, but with the pin low it still loads the hold, which drives the pin high
         odt_pin <= (want_pin && (rogue || !(self_refresh || read_active))) || hold > 1;
      end
   end
endmodule : dot_ctrl_model

/* File: tb/dot_term_ctrl_test.sv */
// self-checking bench for the termination control core
`timescale 1ns/1ps
module dot_term_ctrl_test;
   import dot_pkg::*;
   localparam int L = int'(LAT_RST[3:0]) + int'(LAT_RST[11:8]) - LAT_OFFSET;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic odt_pin, wr_cmd, wr_bc4, read_active, self_refresh, pd_dll_off, dll_syncing;
   logic want_pin, want_wr, want_bc4, rogue, e;
   logic term_on, term_wr, dq_term_on, dqs_term_on;
   logic [3:0] term_div;
   int errors = 0;
   int n_compared = 0;
   dot_term_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .odt_pin(odt_pin), .wr_cmd(wr_cmd), .wr_bc4(wr_bc4), .read_active(read_active),
      .self_refresh(self_refresh), .pd_dll_off(pd_dll_off), .dll_syncing(dll_syncing),
      .term_on(term_on), .term_wr(term_wr), .term_div(term_div), .dq_term_on(dq_term_on),
      .dqs_term_on(dqs_term_on));
   dot_ctrl_model ctl (.pclk(pclk), .presetn(presetn), .want_pin(want_pin), .want_wr(want_wr),
      .want_bc4(want_bc4), .rogue(rogue), .self_refresh(self_refresh), .read_active(read_active),
      .odt_pin(odt_pin), .wr_cmd(wr_cmd), .wr_bc4(wr_bc4));
   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task results;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   // one apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         chk(0, 1, "apb timeout");
         results();
      end
   endtask : apb
   function automatic logic [31:0] mode1(input logic [2:0] c);
      return {22'h0, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0};
   endfunction : mode1
   // pin pulse of four clocks, checks turn-on and turn-off edges
   task nom_pulse(input logic on, input logic [3:0] dv, input int lat);
      want_pin <= 1'b1;
      tick(1);
      want_pin <= 1'b0;
      tick(2 + lat);
      chk(32'(term_on), 0, "term early");
      tick(1);
      chk(32'(term_on), 32'(on), "term on edge");
      chk(32'(term_div), on ? 32'(dv) : 0, "divider");
      chk(32'({dq_term_on, dqs_term_on}), on ? 3 : 0, "lines");
      tick(3);
      chk(32'(term_on), 32'(on), "term held");
      tick(1);
      chk(32'(term_on), 0, "term off edge");
      tick(4);
   endtask : nom_pulse
   task automatic t_regs;
      logic [7:0] ad [6] = '{ADDR_MODE1, ADDR_MODE2, ADDR_LAT, ADDR_CTRL, ADDR_STATUS, 8'h14};
      logic [31:0] rv [6] = '{MODE1_RST, MODE2_RST, LAT_RST, CTRL_RST, 32'h00001000, 32'h00000000};
      for (int k = 0; k < 6; k++) begin
         apb(1'b0, ad[k], 32'h0);
         chk(q, rv[k], "reset value");
         chk(32'(e), k == 5, "slave error");
      end
   endtask : t_regs
   task automatic t_codes;
      logic [3:0] dv [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8, 4'h0, 4'h0};
      apb(1'b1, ADDR_MODE1, mode1(3'h1));
      nom_pulse(1'b0, 4'h0, L);
      apb(1'b1, ADDR_CTRL, 32'h00000001);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ADDR_MODE1, mode1(3'(c)));
         tick(20);
         nom_pulse(c >= 1 && c <= 5, dv[c], L);
      end
   endtask : t_codes
   task t_refuse;
      apb(1'b1, ADDR_MODE1, mode1(3'h1));
      rogue <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         self_refresh <= k == 0;
         read_active <= k == 1;
         nom_pulse(1'b0, 4'h0, L);
      end
      self_refresh <= 1'b0;
      read_active <= 1'b0;
      rogue <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         pd_dll_off <= k == 0;
         dll_syncing <= k == 1;
         nom_pulse(1'b1, 4'h4, 1);
      end
      pd_dll_off <= 1'b0;
      dll_syncing <= 1'b0;
   endtask : t_refuse
   task t_dyn;
      int r;
      apb(1'b1, ADDR_MODE1, mode1(3'h3));
      for (int k = 0; k < 2; k++) begin
         r = k ? RET_BC4 : RET_BL8;
         apb(1'b1, ADDR_MODE2, k ? 32'h00000400 : 32'h00000200);
         tick(20);
         want_pin <= 1'b1;
         tick(4 + L);
         want_wr <= 1'b1;
         want_bc4 <= k == 1;
         tick(1);
         want_wr <= 1'b0;
         tick(1 + L);
         chk(32'(term_wr), 0, "write early");
         tick(1);
         chk(32'({term_wr, term_div}), k ? 32'h12 : 32'h14, "write value");
         tick(r - 1);
         chk(32'(term_wr), 1, "write held");
         tick(1);
         chk(32'({term_wr, term_div}), 32'h06, "back to nominal");
         want_pin <= 1'b0;
         tick(12);
      end
      apb(1'b1, ADDR_MODE2, 32'h00000000);
   endtask : t_dyn
   // single rank: pin tied high, nominal off, write termination on
   task t_tied;
      apb(1'b1, ADDR_MODE1, mode1(3'h0));
      apb(1'b1, ADDR_MODE2, 32'h00000200);
      want_pin <= 1'b1;
      tick(8 + L);
      chk(32'(term_on), 0, "tied pin, nominal off");
      want_wr <= 1'b1;
      want_bc4 <= 1'b0;
      tick(1);
      want_wr <= 1'b0;
      tick(2 + L);
      chk(32'({term_wr, term_div}), 32'h14, "tied pin write value");
      tick(RET_BL8);
      chk(32'(term_on), 0, "tied pin after write");
      want_pin <= 1'b0;
      tick(12);
      apb(1'b1, ADDR_MODE2, 32'h00000000);
   endtask : t_tied
   task t_level;
      apb(1'b1, ADDR_MODE1, mode1(3'h1) | 32'h00000080);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(q[ST_SETTLE]), 1, "uncertainty window");
      tick(20);
      want_pin <= 1'b1;
      tick(5 + L);
      chk(32'({dq_term_on, dqs_term_on}), 1, "leveling lines");
      want_pin <= 1'b0;
      tick(12);
   endtask : t_level
   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {want_pin, want_wr, want_bc4, rogue} = '0;
      {read_active, self_refresh, pd_dll_off, dll_syncing} = '0;
      tick(16);
      presetn <= 1'b1;
      t_regs();
      t_codes();
      t_refuse();
      t_dyn();
      t_tied();
      t_level();
      results();
   end
endmodule : dot_term_ctrl_test
